// [hw/sync_burst_sram_control.sv]
/*
  synchronous burst sram control: cycle decode, 2-bit burst counter,
  byte-lane write steering, flow-through or pipelined read path, single or
  dual cycle deselect, and an axi4-lite slave for mode and status.
  assumes all pin inputs are synchronous to aclk except out_enable_n.
*/
`timescale 1ns/1ps
module sync_burst_sram_control #(
  parameter int ADDR_W = sram_ctl_pkg::ADDR_W
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // synchronous sram control pins
  input wire sram_ctl_pkg::bus_ctl_s bus_ctl,
  input wire logic [ADDR_W-1:0] addr,
  // asynchronous output enable
  input wire logic out_enable_n,
  // data lanes, a in the low nine bits up to h
  input wire logic [sram_ctl_pkg::DATA_W-1:0] data_in,
  output logic [sram_ctl_pkg::DATA_W-1:0] data_out,
  output logic [sram_ctl_pkg::LANES-1:0] data_oe,
  // axi4-lite write address and data
  input wire logic [sram_ctl_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [sram_ctl_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import sram_ctl_pkg::*;

  function automatic logic [BURST_W-1:0] burst_low(input logic [BURST_W-1:0] start,
                                                   input logic [BURST_W-1:0] cnt,
                                                   input logic interleaved);
    logic [BURST_W-1:0] val;
    if (interleaved) begin
      val = start ^ cnt;
    end else begin
      val = start + cnt;
    end
    return val;
  endfunction : burst_low

  // mode and status state
  mode_s mode_q;
  cycle_e kind_q;
  logic last_write_q;
  logic [ADDR_W-1:0] last_addr_q;

  // burst counter state
  logic [ADDR_W-1:BURST_W] base_q;
  logic [BURST_W-1:0] start_q;
  logic [BURST_W-1:0] cnt_q;

  // read path and driver state
  logic rd_stage1_q;
  logic rd_stage2_q;
  logic active_q;
  logic dcd_hold_q;
  logic [DATA_W-1:0] mem_rdata_q;
  logic [DATA_W-1:0] pipe_q;

  // decode
  logic enabled;
  logic write_cond;
  logic is_write;
  logic is_access;
  logic interleaved;
  logic [LANES-1:0] lane_mask;
  logic [ADDR_W-1:0] acc_addr;
  cycle_e kind;

  assign interleaved = mode_q.linear_order_sel_n;
  assign enabled = bus_ctl.chip_sel_second & ~bus_ctl.chip_sel_first_n
                   & ~bus_ctl.chip_sel_third_n;

  always_comb begin
    if (mode_q.sleep_request) begin
      kind = CYC_SLEEP;
    end else if ((bus_ctl.chip_sel_first_n & ~bus_ctl.ctrl_addr_strobe_n)
                 | (~bus_ctl.chip_sel_first_n & ~enabled
                    & (~bus_ctl.cpu_addr_strobe_n | ~bus_ctl.ctrl_addr_strobe_n))) begin
      kind = CYC_DESELECT;
    end else if (enabled & ~bus_ctl.cpu_addr_strobe_n) begin
      kind = CYC_BEGIN_CPU;
    end else if (enabled & ~bus_ctl.ctrl_addr_strobe_n) begin
      kind = CYC_BEGIN_CTRL;
    end else if (~bus_ctl.burst_advance_n) begin
      kind = CYC_CONTINUE;
    end else begin
      kind = CYC_SUSPEND;
    end
  end

  // write condition: global write wins, else the byte gate counts as a write
  assign write_cond = ~bus_ctl.global_write_n | ~bus_ctl.byte_write_gate_n;

  always_comb begin
    if (~bus_ctl.global_write_n) begin
      lane_mask = '1;
    end else if (~bus_ctl.byte_write_gate_n) begin
      lane_mask = ~bus_ctl.lane_write_n;
    end else begin
      lane_mask = '0;
    end
  end

  assign is_access = (kind == CYC_BEGIN_CPU) | (kind == CYC_BEGIN_CTRL)
                     | (kind == CYC_CONTINUE) | (kind == CYC_SUSPEND);
  // a processor-strobed start is always a read
  assign is_write = is_access & (kind != CYC_BEGIN_CPU) & write_cond;

  always_comb begin
    case (kind)
      CYC_BEGIN_CPU, CYC_BEGIN_CTRL: begin
        acc_addr = addr;
      end
      CYC_CONTINUE: begin
        acc_addr = {base_q, burst_low(start_q, cnt_q + BURST_STEP, interleaved)};
      end
      CYC_SUSPEND: begin
        acc_addr = {base_q, burst_low(start_q, cnt_q, interleaved)};
      end
      default: begin
        acc_addr = {base_q, burst_low(start_q, cnt_q, interleaved)};
      end
    endcase
  end

  // burst counter; output enable plays no part, so dummy reads advance too
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_q <= '0;
      start_q <= '0;
      cnt_q <= '0;
    end else begin
      case (kind)
        CYC_BEGIN_CPU, CYC_BEGIN_CTRL: begin
          base_q <= addr[ADDR_W-1:BURST_W];
          start_q <= addr[BURST_W-1:0];
          cnt_q <= '0;
        end
        CYC_CONTINUE: begin
          cnt_q <= cnt_q + BURST_STEP;
        end
        default: begin
          cnt_q <= cnt_q;
        end
      endcase
    end
  end

  sram_array #(
    .ADDR_W(ADDR_W),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_array (
    .aclk(aclk),
    .wr_en(is_write),
    .lane_mask(lane_mask),
    .wdata(data_in),
    .rd_en(is_access & ~is_write),
    .addr(acc_addr),
    .rdata_q(mem_rdata_q)
  );

  // read stages: stage1 marks data in the array register, stage2 in pipe_q
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_stage1_q <= 1'b0;
      rd_stage2_q <= 1'b0;
    end else begin
      rd_stage1_q <= is_access & ~is_write;
      rd_stage2_q <= rd_stage1_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pipe_q <= '0;
    end else if (rd_stage1_q) begin
      pipe_q <= mem_rdata_q;
    end
  end

  assign data_out = mode_q.flow_through_sel_n ? pipe_q : mem_rdata_q;

  // driver state; dcd_hold_q keeps a second deselect from extending the hold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_q <= 1'b0;
      dcd_hold_q <= 1'b0;
    end else begin
      dcd_hold_q <= 1'b0;
      if (kind == CYC_SLEEP || is_write) begin
        active_q <= 1'b0;
      end else if (kind == CYC_DESELECT) begin
        if (mode_q.deselect_mode_sel || dcd_hold_q) begin
          active_q <= 1'b0;
        end else begin
          dcd_hold_q <= 1'b1;
          active_q <= mode_q.flow_through_sel_n ? rd_stage1_q : active_q;
        end
      end else if (mode_q.flow_through_sel_n) begin
        active_q <= rd_stage1_q;
      end else begin
        active_q <= is_access;
      end
    end
  end

  // output enable is combinational so it can cut drivers between edges
  assign data_oe = {LANES{active_q & ~out_enable_n}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kind_q <= CYC_DESELECT;
      last_write_q <= 1'b0;
      last_addr_q <= '0;
    end else begin
      kind_q <= kind;
      if (is_access) begin
        last_write_q <= is_write;
        last_addr_q <= acc_addr;
      end
    end
  end

  // axi4-lite write side: address and data may arrive in either order
  logic aw_have_q;
  logic w_have_q;
  logic [AXI_AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;

  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
  assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= MODE_RESET;
    end else if (wr_fire && aw_addr_q == OFS_MODE && w_strb_q[0]) begin
      mode_q <= w_data_q[$bits(mode_s)-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      // status and last-address are read-only; writes to them are dropped quietly
      s_axi_bresp <= (aw_addr_q == OFS_MODE || aw_addr_q == OFS_STATUS
                      || aw_addr_q == OFS_LAST_ADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // axi4-lite read side
  logic [31:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[ST_KIND_LSB +: 3] = kind_q;
    status_word[ST_LOW_LSB +: BURST_W] = burst_low(start_q, cnt_q, interleaved);
    status_word[ST_ACTIVE_BIT] = active_q;
    status_word[ST_WRITE_BIT] = last_write_q;
    status_word[ST_SLEEP_BIT] = mode_q.sleep_request;
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        OFS_MODE: begin
          s_axi_rdata <= 32'(mode_q);
        end
        OFS_STATUS: begin
          s_axi_rdata <= status_word;
        end
        OFS_LAST_ADDR: begin
          s_axi_rdata <= 32'(last_addr_q);
        end
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : sync_burst_sram_control

// [hw/sram_ctl_pkg.sv]
/*
  shared constants and carriers for the synchronous burst sram control block.
  assumes a single clock domain and a 32-bit axi4-lite register bus.
*/
package sram_ctl_pkg;

  // array geometry: eight 9-bit lanes, 512k words
  localparam int LANES = 8;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int ADDR_W = 19;
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

  // register bus
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] OFS_MODE = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_LAST_ADDR = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // status register field positions
  localparam int ST_KIND_LSB = 0;
  localparam int ST_LOW_LSB = 3;
  localparam int ST_ACTIVE_BIT = 5;
  localparam int ST_WRITE_BIT = 6;
  localparam int ST_SLEEP_BIT = 7;

  // decoded bus cycle
  typedef enum logic [2:0] {
    CYC_DESELECT,
    CYC_BEGIN_CPU,
    CYC_BEGIN_CTRL,
    CYC_CONTINUE,
    CYC_SUSPEND,
    CYC_SLEEP
  } cycle_e;

  // synchronous control pins, bit 0 of lane_write_n is lane a
  typedef struct packed {
    logic chip_sel_first_n;
    logic chip_sel_second;
    logic chip_sel_third_n;
    logic cpu_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_advance_n;
    logic global_write_n;
    logic byte_write_gate_n;
    logic [LANES-1:0] lane_write_n;
  } bus_ctl_s;

  // mode register, bit 0 upward: order, flow, deselect, sleep
  typedef struct packed {
    logic sleep_request;
    logic deselect_mode_sel;
    logic flow_through_sel_n;
    logic linear_order_sel_n;
  } mode_s;

  // defaults: interleaved, pipeline, single cycle deselect, awake
  localparam mode_s MODE_RESET = 4'h7;

endpackage : sram_ctl_pkg

// [hw/sram_array.sv]
/*
  byte-lane writable storage array with a registered read port.
  assumes write and read never address it in the same cycle.
*/
`timescale 1ns/1ps
module sram_array #(
  parameter int ADDR_W = 19,
  parameter int LANES = 8,
  parameter int LANE_W = 9
) (
  // clock
  input wire logic aclk,
  // write port
  input wire logic wr_en,
  input wire logic [LANES-1:0] lane_mask,
  input wire logic [LANES*LANE_W-1:0] wdata,
  // shared address and read port
  input wire logic rd_en,
  input wire logic [ADDR_W-1:0] addr,
  output logic [LANES*LANE_W-1:0] rdata_q
);

  logic [LANES*LANE_W-1:0] mem [2**ADDR_W];

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      for (int i = 0; i < LANES; i++) begin
        if (lane_mask[i]) begin
          mem[addr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // read data leaves through a register, so it trails the address by one edge
  always_ff @(posedge aclk) begin
    if (rd_en) begin
      rdata_q <= mem[addr];
    end
  end

endmodule : sram_array

// [dv/sync_burst_sram_control_assertions.sv]
/* port assertions for the sram control block.
   assumes a bind from the bench top. */
`timescale 1ns/1ps
module sbsc_assertions (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // sram pins
  input wire sram_ctl_pkg::bus_ctl_s bus_ctl,
  input wire logic out_enable_n,
  input wire logic [sram_ctl_pkg::LANES-1:0] data_oe,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sram_ctl_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import sram_ctl_pkg::*;
  logic en, desel, wr;
  assign en = bus_ctl.chip_sel_second & ~bus_ctl.chip_sel_first_n & ~bus_ctl.chip_sel_third_n;
  assign desel = bus_ctl.chip_sel_first_n ? ~bus_ctl.ctrl_addr_strobe_n
    : ~en & ~(bus_ctl.cpu_addr_strobe_n & bus_ctl.ctrl_addr_strobe_n);
  assign wr = en & bus_ctl.cpu_addr_strobe_n & ~bus_ctl.ctrl_addr_strobe_n
    & ~(bus_ctl.global_write_n & bus_ctl.byte_write_gate_n);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // two in a row covers the extra hold of dual deselect
  sequence s_desel2;
    desel [*2];
  endsequence
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_oe_gate;
    out_enable_n |-> data_oe == '0;
  endproperty
  a_oe_gate: assert property (p_oe_gate)
    else $error("drivers on while output enable high");
  property p_write_off;
    wr |=> data_oe == '0;
  endproperty
  a_write_off: assert property (p_write_off)
    else $error("drivers on after write");
  property p_desel_off;
    s_desel2 |=> data_oe == '0;
  endproperty
  a_desel_off: assert property (p_desel_off)
    else $error("drivers on after deselect");
  property p_b_answer;
    s_wtake |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer)
    else $error("no write response");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("no read answer");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > OFS_LAST_ADDR
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
endmodule : sbsc_assertions

// [dv/sram_host_model.sv]
/* host model: a controller issuing one synchronous bus cycle per clock.
   assumes the bench calls cyc back to back. */
`timescale 1ns/1ps
module sram_host_model (
  // clock
  input wire logic aclk,
  // pins toward the device
  output sram_ctl_pkg::bus_ctl_s bus_ctl,
  output logic [5:0] addr,
  output logic [sram_ctl_pkg::DATA_W-1:0] data_in
);
  import sram_ctl_pkg::*;
  initial begin
    bus_ctl = 16'hb7ff;
    addr = '0;
    data_in = '0;
  end
  // data toggles outside writes so a stale value never looks valid
  task automatic cyc(input logic [7:0] h, input logic [7:0] l, input logic [5:0] a,
                     input logic [DATA_W-1:0] d);
    @(posedge aclk);
    bus_ctl <= {h, l};
    addr <= a;
    data_in <= (h[1] & h[0]) ? ~data_in : d;
  endtask : cyc
endmodule : sram_host_model

// [dv/sync_burst_sram_control_tb_top.sv]
/* bench top: host model on the pins, axi4-lite master on the registers.
   assumes package, design, host model and checker compiled first. */
`timescale 1ns/1ps
module sync_burst_sram_control_tb_top;
  import sram_ctl_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic out_enable_n = 1'h0;
  bus_ctl_s bus_ctl;
  logic [5:0] addr;
  logic [DATA_W-1:0] data_in, data_out;
  logic [LANES-1:0] data_oe;
  logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] seed = 32'h8;
  logic [DATA_W-1:0] mem [64];
  logic [5:0] ad [8];
  logic [7:0] pat [8] = '{8'h55, 8'hb7, 8'h0f, 8'h77, 8'h4c, 8'h57, 8'hbb, 8'hbf};
  logic [3:0] kind [8] = '{4'ha, 4'h8, 4'h8, 4'h8, 4'h1, 4'h2, 4'h3, 4'h4};
  int miscompares = 0;
  int check_count = 0;
  int lat [2];

  sync_burst_sram_control #(.ADDR_W(6)) dut (.aclk, .aresetn, .bus_ctl, .addr, .out_enable_n,
    .data_in, .data_out, .data_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  sram_host_model host (.aclk, .bus_ctl, .addr, .data_in);

  initial begin
    forever #50 aclk = ~aclk;
  end

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [1:0] nxt(input logic [1:0] s, input logic [1:0] k, input logic il);
    return il ? s ^ k : s + k;
  endfunction : nxt

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
      input logic [DATA_W-1:0] d, input logic [7:0] m);
    for (int i = 0; i < LANES; i++) begin
      if (!m[i]) begin
        o[i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
      end
    end
    return o;
  endfunction : merge

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    fork
      begin
        do @(posedge aclk); while (s_axi_awready !== 1'h1);
        s_axi_awvalid <= 1'h0;
      end
      begin
        do @(posedge aclk); while (s_axi_wready !== 1'h1);
        s_axi_wvalid <= 1'h0;
      end
    join
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    check(DATA_W'(s_axi_bresp), DATA_W'(RESP_OKAY));
    s_axi_bready <= 1'h1;
    @(posedge aclk);
    s_axi_bready <= 1'h0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h1;
    @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : axr

  // suspend repeats the address, so the data settles whatever the read path
  task automatic rd(input logic [5:0] a, input int f);
    int n;
    n = 0;
    host.cyc(8'h57, 8'hff, a, '0);
    do begin
      host.cyc(8'hbf, 8'hff, a, '0);
      n++;
    end while (data_out !== mem[a] && n < 6);
    lat[f] = n;
    host.cyc(8'hbf, 8'hff, a, '0);
    check(data_out, mem[a]);
    check(DATA_W'(data_oe), DATA_W'(8'hff));
  endtask : rd

  // the whole run needs well under 3000 clocks
  initial begin
    #1000000;
    miscompares++;
    give_verdict();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [95:0] w;
    logic [7:0] m;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    axr(OFS_MODE, d, r);
    check(DATA_W'(d), DATA_W'(32'h7));
    axr(8'h0c, d, r);
    check(DATA_W'({d, r}), DATA_W'({32'h0, RESP_SLVERR}));
    foreach (pat[i]) begin
      host.cyc(pat[i], 8'hff, '0, '0);
      // the kind field is registered, so let the pattern be captured first
      @(posedge aclk);
      axr(OFS_STATUS, d, r);
      check(DATA_W'({d[6], d[2:0]}), DATA_W'(kind[i]));
    end
    out_enable_n <= 1'h1;
    for (int o = 0; o < 2; o++) begin
      axw(OFS_MODE, 32'h6 | 32'(o));
      for (int k = 0; k < 20; k++) begin
        host.cyc(8'h57, 8'hff, 6'(k / 5), '0);
        repeat (k % 5) host.cyc(8'hbb, 8'hff, '0, '0);
        host.cyc(8'hbf, 8'hff, '0, '0);
        axr(OFS_STATUS, d, r);
        check(DATA_W'(d[4:3]), DATA_W'(nxt(2'(k / 5), 2'(k % 5), o[0])));
      end
    end
    out_enable_n <= 1'h0;
    for (int f = 0; f < 2; f++) begin
      axw(OFS_MODE, f ? 32'h7 : 32'h1);
      for (int i = 0; i < 8; i++) begin
        w = {rnd(), rnd(), rnd()};
        ad[i] = {3'(i), w[74:72]};
        mem[ad[i]] = w[71:0];
        host.cyc(8'h54, w[87:80], ad[i], w[71:0]);
        w = {rnd(), rnd(), rnd()};
        m = i == 0 ? 8'hff : w[95:88];
        mem[ad[i]] = merge(mem[ad[i]], w[71:0], m);
        host.cyc(8'h56, m, ad[i], w[71:0]);
      end
      repeat (3) host.cyc(8'hb7, 8'hff, '0, '0);
      foreach (ad[i]) rd(ad[i], f);
      #20 out_enable_n = 1'h1;
      #1 check(DATA_W'(data_oe), '0);
      out_enable_n = 1'h0;
      // dual deselect keeps the drivers one cycle longer than single deselect
      host.cyc(8'hb7, 8'hff, '0, '0);
      repeat (2) @(posedge aclk);
      check(DATA_W'(data_oe), DATA_W'(f ? 8'h00 : 8'hff));
      @(posedge aclk);
      check(DATA_W'(data_oe), '0);
    end
    check(DATA_W'(lat[1]), DATA_W'(lat[0] + 1));
    axw(OFS_MODE, 32'hf);
    host.cyc(8'h54, 8'h00, ad[0], ~mem[ad[0]]);
    axr(OFS_STATUS, d, r);
    check(DATA_W'({d[7], d[2:0]}), DATA_W'(4'hd));
    host.cyc(8'hb7, 8'hff, '0, '0);
    axw(OFS_MODE, 32'h7);
    rd(ad[0], 1);
    give_verdict();
  end
endmodule : sync_burst_sram_control_tb_top

bind sync_burst_sram_control sbsc_assertions u_chk (.aclk, .aresetn, .bus_ctl, .out_enable_n,
  .data_oe, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
